// ==== rtl/ebw_adapter.sv ====
`timescale 1ns/10ps
// Functional notes
// (R1) drive 24-bit external address of the location being accessed
// (R2) 32-bit two-way data bus: driven on writes, sampled on reads
// (R3) bank 0 width comes from a two-pin strap, not a register
// (R4) strap 01 is 8-bit, 10 is 16-bit, 11 is 32-bit
// (R5) output enable low only while reading an I/O device
// (R6) eight I/O chip selects, only the accessed bank's one low
// (R7) slow device holds the access while its hold input is low
// (R8) drive sdram clock enable high
// (R9) two sdram chip selects, one per sdram bank
// (R10) drive row and column strobes to the sdram
// (R11) one strobe is 16-bit write strobe and sdram write enable
// (R12) outside master requests the bus; grant answers on release
// (R13) endian pin selects byte order for all external accesses
// (R14) halfword store replicated on both halves, byte on four lanes
// (R15) 32-bit big: words byte-reversed, halves and bytes by offset
// (R16) 32-bit little: words unchanged, halves and bytes by offset
// (R17) 16-bit big word: upper half swapped at EA, lower at EA+1
// (R18) 16-bit big bytes: even on lane 0, odd on lane 1
// (R19) 16-bit little word: upper at EA+1 first, lower at EA
// (R20) 8-bit big: ascending addresses, most significant byte first
// (R21) 8-bit little: start at highest address, descend to base
// (R22) loads assemble most significant part first, result at end
// (R23) parts of a split transfer run back to back, uninterrupted
module ebw_adapter
    import ebw_pkg::*;
#(
    parameter logic [1:0] IO_WIDTH_LG = LG_B4,
    parameter logic [1:0] SD_WIDTH_LG = LG_B4
) (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire logic                i_req_valid,
    input  wire ebw_req_t            i_req,
    output logic                     o_req_ready,
    output logic                     o_rsp_valid,
    output logic [DATA_W-1:0]        o_rsp_rdata,
    output logic [ADDR_W-1:0]        o_addr,
    input  wire logic [DATA_W-1:0]   i_data,
    output logic [DATA_W-1:0]        o_data,
    output logic                     o_data_oe,
    input  wire logic [1:0]          i_bank0_width_strap,
    input  wire logic                i_endian_select,
    output logic                     o_output_enable_n,
    output logic [IO_BANKS-1:0]      o_io_chip_select_n,
    input  wire logic                i_slow_device_hold_n,
    output logic                     o_bus_clock_out,
    output logic                     o_sdram_clock_enable,
    output logic [SD_BANKS-1:0]      o_sdram_chip_select_n,
    output logic                     o_row_strobe_n,
    output logic                     o_column_strobe_n,
    output logic [3:0]               o_byte_lane_enable_n,
    output logic                     o_halfword_write_strobe_n,
    input  wire logic                i_ext_master_request,
    output logic                     o_ext_master_grant
);

    // reverse byte order inside a part of 1, 2 or 4 bytes
    function automatic logic [31:0] swap_part(input logic [31:0] d, input logic [1:0] lg);
        case (lg)
            LG_B1:   swap_part = {24'h0, d[7:0]};
            LG_B2:   swap_part = {16'h0, d[7:0], d[15:8]};
            default: swap_part = {d[7:0], d[15:8], d[23:16], d[31:24]};
        endcase
    endfunction

    // keep only the low part of 1, 2 or 4 bytes
    function automatic logic [31:0] mask_part(input logic [31:0] d, input logic [1:0] lg);
        case (lg)
            LG_B1:   mask_part = {24'h0, d[7:0]};
            LG_B2:   mask_part = {16'h0, d[15:0]};
            default: mask_part = d;
        endcase
    endfunction

    // copy a byte or halfword onto every lane of the internal bus
    function automatic logic [31:0] replicate(input logic [31:0] d, input logic [1:0] lg);
        case (lg)
            LG_B1:   replicate = {4{d[7:0]}};
            LG_B2:   replicate = {2{d[15:0]}};
            default: replicate = d;
        endcase
    endfunction

    ebw_pins_t   pin_meta;
    ebw_pins_t   pin_s;
    ebw_pins_t   pin_now;
    ebw_state_t  state;
    ebw_state_t  next_state;
    ebw_req_t    req;
    ebw_req_t    next_req;
    logic        big;
    logic        next_big;
    logic        strap_done;
    logic [1:0]  bank0_lg;
    logic [1:0]  beat;
    logic [1:0]  next_beat;
    logic [1:0]  cnt;
    logic [1:0]  next_cnt;
    logic [31:0] acc;
    logic [31:0] next_acc;

    // every pin input passes two flops; not reset so the strap is valid at release
    assign pin_now = '{strap: i_bank0_width_strap, hold_n: i_slow_device_hold_n,
                       mreq: i_ext_master_request, big: i_endian_select, data: i_data};

    always_ff @(posedge i_clk) begin
        pin_meta <= pin_now;
        pin_s    <= pin_meta;
    end

    // bank 0 width caught once, in the first clock after reset release
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            strap_done <= 1'b0;
            bank0_lg   <= LG_B4;
        end else if (!strap_done) begin
            strap_done <= 1'b1; // R3
            bank0_lg   <= (pin_s.strap == STRAP_W8)  ? LG_B1 : // R4
                          (pin_s.strap == STRAP_W16) ? LG_B2 : LG_B4;
        end
    end

    // bank decode and geometry of the current part
    logic        sd_sel;
    logic        sd_idx;
    logic [2:0]  io_bank;
    logic [1:0]  width_lg;
    logic [1:0]  part_lg;
    logic [1:0]  n_lg;
    logic [1:0]  beats_m1;
    logic [1:0]  pidx;
    logic [1:0]  lane;
    logic [5:0]  sh_part;
    logic [4:0]  lane_sh;
    logic [3:0]  lane_en;
    logic        last_beat;
    assign sd_sel   = (req.addr[31:30] == SEL_SD0) || (req.addr[31:30] == SEL_SD1);
    assign sd_idx   = (req.addr[31:30] == SEL_SD1);
    assign io_bank  = req.addr[BANK_LSB +: BANK_W];
    assign width_lg = sd_sel ? SD_WIDTH_LG : (io_bank == 3'h0) ? bank0_lg : IO_WIDTH_LG;
    assign part_lg  = (req.size_lg < width_lg) ? req.size_lg : width_lg;
    assign n_lg     = req.size_lg - part_lg;
    assign beats_m1 = 2'((3'h1 << n_lg) - 3'h1);
    assign last_beat = (beat == beats_m1);
    // part index counted from the least significant end
    assign pidx     = beats_m1 - beat; // R22
    assign sh_part  = 6'({1'b0, pidx, 3'h0}) << part_lg;
    // narrow parts sit on the lane named by the low address bits
    assign lane     = req.addr[1:0] & 2'((3'h1 << width_lg) - 3'h1)
                      & ~2'((3'h1 << part_lg) - 3'h1); // R15 R16 R18 R19
    assign lane_sh  = 5'({lane, 3'h0});
    assign lane_en  = 4'(4'((5'h1 << (3'h1 << part_lg)) - 5'h1) << lane);

    // store path: big endian swaps bytes inside each part
    logic [31:0] tx_part;
    logic [31:0] tx_data;
    logic [23:0] ext_base;
    logic [23:0] ext_addr;
    assign tx_part  = mask_part(req.wdata >> sh_part, part_lg);
    assign tx_data  = (big ? swap_part(tx_part, part_lg) : tx_part) << lane_sh; // R15 R17
    assign ext_base = 24'(req.addr[23:0] >> width_lg);
    // big walks addresses upward, little starts at the top and walks down
    assign ext_addr = ext_base + 24'(big ? beat : pidx); // R17 R19 R20 R21

    // load path: undo lane and swap, shift in behind earlier parts
    logic [31:0] rx_part;
    logic [31:0] rx_data;
    logic [31:0] acc_shift;
    assign rx_part   = mask_part(pin_s.data >> lane_sh, part_lg);
    assign rx_data   = big ? swap_part(rx_part, part_lg) : rx_part;
    assign acc_shift = acc << (6'h8 << part_lg);

    // request taken only in idle while ready shows
    logic take;
    assign take = (state == ST_IDLE) && o_req_ready && i_req_valid;

    // next state: internal request wins over an outside master in idle
    always_comb begin
        next_state = state;
        next_req   = req;
        next_big   = big;
        next_beat  = beat;
        next_cnt   = cnt;
        next_acc   = acc;
        unique case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state     = ST_SETUP;
                    next_req       = i_req;
                    next_req.wdata = replicate(i_req.wdata, i_req.size_lg); // R14
                    next_big       = pin_s.big; // R13
                    next_beat      = 2'h0;
                    next_acc       = 32'h0;
                end else if (pin_s.mreq) begin
                    next_state = ST_GRANT; // R12
                end
            end
            ST_SETUP: begin
                next_state = ST_STROBE;
                next_cnt   = STROBE_MIN_M1;
            end
            ST_STROBE: begin
                if (cnt != 2'h0) begin
                    next_cnt = cnt - 2'h1;
                end else if (pin_s.hold_n) begin // R7
                    next_acc = acc_shift | rx_data; // R22
                    if (last_beat) begin
                        next_state = ST_DONE;
                    end else begin
                        next_state = ST_SETUP; // R23
                        next_beat  = beat + 2'h1;
                    end
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            ST_GRANT: begin
                if (!pin_s.mreq) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= ST_IDLE;
            req   <= '0;
            big   <= 1'b0;
            beat  <= 2'h0;
            cnt   <= 2'h0;
            acc   <= 32'h0;
        end else begin
            state <= next_state;
            req   <= next_req;
            big   <= next_big;
            beat  <= next_beat;
            cnt   <= next_cnt;
            acc   <= next_acc;
        end
    end

    // pin phase decode; pins lag the sequencer by one flop
    logic active;
    logic strobe;
    assign active = (state == ST_SETUP) || (state == ST_STROBE);
    assign strobe = (state == ST_STROBE);

    // internal side answer: the result is replicated like the bus view
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_req_ready <= 1'b0;
            o_rsp_valid <= 1'b0;
            o_rsp_rdata <= 32'h0;
        end else begin
            o_req_ready <= (next_state == ST_IDLE) && strap_done;
            o_rsp_valid <= (state == ST_DONE);
            o_rsp_rdata <= replicate(acc, req.size_lg); // R22
        end
    end

    // external pins, all straight from flops
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_addr                    <= '0;
            o_data                    <= '0;
            o_data_oe                 <= 1'b0;
            o_output_enable_n         <= 1'b1;
            o_io_chip_select_n        <= '1;
            o_sdram_chip_select_n     <= '1;
            o_row_strobe_n            <= 1'b1;
            o_column_strobe_n         <= 1'b1;
            o_byte_lane_enable_n      <= 4'hf;
            o_halfword_write_strobe_n <= 1'b1;
            o_ext_master_grant        <= 1'b0;
            o_sdram_clock_enable      <= 1'b0;
            o_bus_clock_out           <= 1'b0;
        end else begin
            o_addr                    <= active ? ext_addr : '0; // R1
            o_data                    <= tx_data; // R2
            o_data_oe                 <= active && req.write; // R2
            o_output_enable_n         <= !(strobe && !sd_sel && !req.write); // R5
            o_io_chip_select_n        <= (active && !sd_sel) ? ~(8'h1 << io_bank) : '1; // R6
            o_sdram_chip_select_n     <= (active && sd_sel) ? ~(2'h1 << sd_idx) : '1; // R9
            o_row_strobe_n            <= !((state == ST_SETUP) && sd_sel); // R10
            o_column_strobe_n         <= !(strobe && sd_sel); // R10
            o_byte_lane_enable_n      <= active ? ~lane_en : 4'hf;
            o_halfword_write_strobe_n <= !(strobe && req.write
                                           && (sd_sel || width_lg == LG_B2)); // R11
            o_ext_master_grant        <= (state == ST_GRANT); // R12
            o_sdram_clock_enable      <= 1'b1; // R8
            o_bus_clock_out           <= !o_bus_clock_out; // half the system clock
        end
    end

    // checks on the pin sequence
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    addr_stable_a: assert property ((strobe && $past(state) == ST_STROBE) |=> $stable(o_addr)) // R1
        else $error("address moved inside one strobe");
    write_drive_a: assert property (o_data_oe |-> $past(req.write) && $past(active)) // R2
        else $error("data bus driven outside a write");
    strap_fixed_a: assert property ((strap_done && $past(strap_done)) |-> $stable(bank0_lg)) // R3
        else $error("bank 0 width changed after reset");
    strap_decode_a: assert property (($rose(strap_done) && $past(pin_s.strap) == STRAP_W16)
        |-> bank0_lg == LG_B2) // R4
        else $error("strap 10 did not give a 16-bit bank 0");
    read_strobe_a: assert property (!o_output_enable_n |-> $past(strobe && !req.write)) // R5
        else $error("output enable low outside a read strobe");
    one_select_a: assert property ($onehot0(~o_io_chip_select_n)) // R6
        else $error("more than one I/O chip select low");
    hold_extend_a: assert property ((strobe && cnt == 2'h0 && !pin_s.hold_n)
        |=> state == ST_STROBE [*1] ##1 o_io_chip_select_n == $past(o_io_chip_select_n)) // R7
        else $error("held access did not stay in strobe");
    sd_select_a: assert property ($onehot0(~o_sdram_chip_select_n)) // R9
        else $error("both sdram chip selects low");
    row_strobe_a: assert property (!o_row_strobe_n |-> !(&o_sdram_chip_select_n)) // R10
        else $error("row strobe without an sdram select");
    grant_release_a: assert property (o_ext_master_grant |-> !o_data_oe && &o_io_chip_select_n) // R12
        else $error("bus driven while granted away");
    back_to_back_a: assert property ((state == ST_SETUP && beat != 2'h0)
        |-> $past(state) == ST_STROBE) // R23
        else $error("split transfer interrupted");
    rsp_pulse_a: assert property (o_rsp_valid |=> !o_rsp_valid) // R22
        else $error("response longer than one cycle");

    word_narrow_c: cover property (strobe && beat == 2'h3 && last_beat);
    grant_c:       cover property (o_ext_master_grant ##1 !o_ext_master_grant);
    hold_c:        cover property (strobe && cnt == 2'h0 && !pin_s.hold_n);

endmodule // ebw_adapter

// ==== rtl/ebw_pkg.sv ====
package ebw_pkg;
    // pin group widths
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int IO_BANKS = 8;
    localparam int SD_BANKS = 2;
    localparam int BANK_LSB = 24;
    localparam int BANK_W = 3;

    // width strap codes for bank 0
    localparam logic [1:0] STRAP_W8 = 2'h1;
    localparam logic [1:0] STRAP_W16 = 2'h2;
    localparam logic [1:0] STRAP_W32 = 2'h3;

    // log2 of byte lanes: used for access size and bus width
    localparam logic [1:0] LG_B1 = 2'h0;
    localparam logic [1:0] LG_B2 = 2'h1;
    localparam logic [1:0] LG_B4 = 2'h2;

    // top address bits that select an sdram bank
    localparam logic [1:0] SEL_SD0 = 2'h1;
    localparam logic [1:0] SEL_SD1 = 2'h2;

    // least strobe length in clocks, less one; covers the input synchroniser lag
    localparam logic [1:0] STROBE_MIN_M1 = 2'h3;

    typedef struct packed {
        logic [31:0] addr;
        logic [1:0]  size_lg;
        logic        write;
        logic [31:0] wdata;
    } ebw_req_t;

    typedef struct packed {
        logic [1:0]  strap;
        logic        hold_n;
        logic        mreq;
        logic        big;
        logic [31:0] data;
    } ebw_pins_t;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_SETUP  = 5'h02,
        ST_STROBE = 5'h04,
        ST_DONE   = 5'h08,
        ST_GRANT  = 5'h10
    } ebw_state_t;
endpackage

// ==== testbench/ebw_adapter_test.sv ====
`timescale 1ns/10ps
module ebw_adapter_test
    import ebw_pkg::*;
;
    typedef struct packed {
        logic [31:0] a;
        logic [1:0]  sz;
        logic [1:0]  w;
        logic        wr;
        logic        big;
        logic        slow;
        logic [31:0] exp;
        logic [31:0] take;
    } ebw_tb_note_t;

    logic             i_clk = 1'b0;
    logic             i_rst = 1'b1;
    logic             req_valid = 1'b0;
    ebw_req_t         req = '0;
    logic [1:0]       strap = 2'h3;
    logic [1:0]       w0 = LG_B4;
    logic [1:0]       mw = LG_B4;
    logic             big = 1'b0;
    logic             slow = 1'b0;
    logic             mreq = 1'b0;
    logic [31:0]      rnd = 32'hfeb67bc4;
    logic [31:0]      a = '0;
    logic [31:0]      d = '0;
    logic [31:0]      cyc = '0;
    int               error_cnt = 0;
    int               n_checks = 0;
    int               parts;
    int               k;
    ebw_tb_note_t     m;
    ebw_tb_note_t     q[$];
    wire logic        ready, rsp_valid, data_oe, oe_n, hold_n, bclk, cke, ras_n, cas_n, we_n, grant;
    wire logic [31:0] rdata, dout, din, mdata;
    wire logic [23:0] addr, first;
    wire logic [7:0]  io_cs_n, oe_cnt, we_cnt, cas_cnt;
    wire logic [1:0]  sd_cs_n;
    wire logic [3:0]  lane_n;
    wire logic [9:0]  fsel;

    // bus level: the adapter drives on writes, the memory model otherwise
    assign din = data_oe ? dout : mdata;

    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 32'h1;

    ebw_adapter i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_req_valid(req_valid), .i_req(req),
        .o_req_ready(ready), .o_rsp_valid(rsp_valid), .o_rsp_rdata(rdata), .o_addr(addr),
        .i_data(din), .o_data(dout), .o_data_oe(data_oe), .i_bank0_width_strap(strap),
        .i_endian_select(big), .o_output_enable_n(oe_n), .o_io_chip_select_n(io_cs_n),
        .i_slow_device_hold_n(hold_n), .o_bus_clock_out(bclk), .o_sdram_clock_enable(cke),
        .o_sdram_chip_select_n(sd_cs_n), .o_row_strobe_n(ras_n), .o_column_strobe_n(cas_n),
        .o_byte_lane_enable_n(lane_n), .o_halfword_write_strobe_n(we_n),
        .i_ext_master_request(mreq), .o_ext_master_grant(grant));

    ebw_mem_model i_mdl (
        .i_clk(i_clk), .i_slow(slow), .i_wlg(mw), .i_addr(addr), .i_data(din),
        .i_doe(data_oe), .i_oe_n(oe_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_lane_n(lane_n),
        .i_sel_n({sd_cs_n, io_cs_n}), .o_data(mdata), .o_hold_n(hold_n), .o_first(first),
        .o_fsel(fsel), .o_oe_cnt(oe_cnt), .o_we_cnt(we_cnt), .o_cas_cnt(cas_cnt));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    // value bytes at their external byte places; big endian puts the top byte lowest
    function automatic logic [31:0] gather(input ebw_tb_note_t n);
        logic [31:0] v;
        logic [11:0] p;
        v = '0;
        for (int j = 0; j < (1 << n.sz); j++) begin
            p = n.a[11:0] + 12'(n.big ? (1 << n.sz) - 1 - j : j);
            v[8*j+:8] = i_mdl.mem[p];
        end
        return v;
    endfunction

    // strap is held through reset so the capture after release sees it settled
    task automatic rst_with(input logic [1:0] s);
        strap <= s;
        i_rst <= 1'b1;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        w0 = (s == 2'h0) ? LG_B4 : s - 2'h1;
        repeat (3) @(posedge i_clk);
        check(cke, 1'b1);
    endtask

    // one transfer; waits for its response so notes and model settings stay paired
    task automatic xfer(input logic [1:0] sz, input logic wr, input logic sl, input logic g);
        ebw_tb_note_t n;
        int           t;
        n.a = a;
        n.sz = sz;
        n.w = (a[31:30] != 2'h0 || a[26:24] != 3'h0) ? LG_B4 : w0;
        n.wr = wr;
        n.big = big;
        n.slow = sl;
        n.exp = sz == 2'h0 ? {4{d[7:0]}} : sz == 2'h1 ? {2{d[15:0]}} : d;
        if (wr) n.exp = d & ((32'h1 << (8 << sz)) - 32'h1);
        mw <= n.w;
        slow <= sl;
        req <= '{addr: a, size_lg: sz, write: wr, wdata: d};
        req_valid <= 1'b1;
        t = 0;
        do begin @(posedge i_clk); t++; end while (ready !== 1'b1 && t < 300);
        if (ready !== 1'b1) error_cnt++; // a request never taken counts as a mismatch
        n.take = cyc;
        q.push_back(n);
        req_valid <= 1'b0;
        repeat (3) @(posedge i_clk);
        mreq <= g;
        t = 0;
        while (q.size() != 0 && t < 400) begin @(posedge i_clk); t++; end
        if (q.size() != 0) error_cnt++; // a missing response counts as a mismatch
    endtask

    // response watcher: every result is matched against the oldest note
    always @(posedge i_clk) begin
        if (!i_rst && rsp_valid === 1'b1) begin
            m = (q.size() != 0) ? q.pop_front() : '0;
            parts = (m.sz > m.w) ? 1 << (m.sz - m.w) : 1;
            if (m.wr) check(gather(m), m.exp);
            else check(rdata, m.exp);
            check(first, (m.big ? m.a[23:0] : m.a[23:0] + 24'((1 << m.sz) - 1)) >> m.w);
            check(fsel, m.a[31:30] == 2'h1 ? 10'h2ff : m.a[31:30] == 2'h2 ? 10'h1ff
                        : {2'h3, ~(8'h01 << m.a[26:24])});
            check(oe_cnt != 0, !m.wr && m.a[31:30] == 2'h0);
            check(we_cnt != 0, m.wr && (m.w == LG_B2 || m.a[31:30] != 2'h0));
            check(cas_cnt != 0, m.a[31:30] != 2'h0);
            check(grant, 1'b0);
            check(cyc - m.take > parts * 5 + 4, m.slow);
            check(cyc - m.take >= parts * 5, 1'b1);
        end
    end

    initial begin
        // every strap code and both byte orders, each size at random places
        for (int s = 0; s < 4; s++) begin
            rst_with(2'(s));
            for (int b = 0; b < 2; b++) begin
                big <= b[0];
                repeat (4) @(posedge i_clk);
                for (int z = 0; z < 9; z++) begin
                    rnd = lfsr(rnd);
                    a = {20'h0, rnd[11:0]} & ~((32'h1 << (z / 3)) - 32'h1);
                    rnd = lfsr(rnd);
                    d = rnd;
                    xfer(2'(z / 3), 1'b1, z % 3 == 2, 1'b0);
                    xfer(2'(z / 3), 1'b0, 1'b0, 1'b0);
                end
            end
        end
        // an upper i/o bank and both sdram banks
        rst_with(2'h1);
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 32'h03000044 : (i == 1) ? 32'h40000088 : 32'h800000c8;
            rnd = lfsr(rnd);
            d = rnd;
            xfer(2'h2, 1'b1, 1'b0, 1'b0);
            xfer(2'h2, 1'b0, 1'b0, 1'b0);
        end
        // outside master asks in mid-split; grant only after the last part
        a = 32'h00000100;
        xfer(2'h2, 1'b1, 1'b0, 1'b1);
        for (k = 0; k < 12 && grant !== 1'b1; k++) @(posedge i_clk);
        check(grant, 1'b1);
        check(ready, 1'b0);
        check(data_oe, 1'b0);
        mreq <= 1'b0;
        for (k = 0; k < 12 && grant !== 1'b0; k++) @(posedge i_clk);
        check(grant, 1'b0);
        xfer(2'h2, 1'b0, 1'b0, 1'b0);
        report_and_stop;
    end

    // hang guard, well past the expected run length
    initial begin
        #4000000;
        error_cnt++;
        report_and_stop;
    end
endmodule // ebw_adapter_test

// ==== testbench/ebw_mem_model.sv ====
`timescale 1ns/10ps
// external devices on the bank pins; bytes kept at their external byte address
module ebw_mem_model
    import ebw_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_slow,
    input  wire logic [1:0]        i_wlg,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_data,
    input  wire logic              i_doe,
    input  wire logic              i_oe_n,
    input  wire logic              i_cas_n,
    input  wire logic              i_we_n,
    input  wire logic [3:0]        i_lane_n,
    input  wire logic [9:0]        i_sel_n,
    output logic [DATA_W-1:0]      o_data,
    output logic                   o_hold_n,
    output logic [ADDR_W-1:0]      o_first,
    output logic [9:0]             o_fsel,
    output logic [7:0]             o_oe_cnt,
    output logic [7:0]             o_we_cnt,
    output logic [7:0]             o_cas_cnt
);
    logic [7:0] mem [0:4095];
    logic [7:0] pat   = 8'h5a;
    logic [7:0] hcnt  = 8'h00;
    logic       sel_q = 1'b0;
    wire logic  sel   = ~&i_sel_n;
    wire logic  start = sel && !sel_q;
    wire logic  drive = sel && !i_doe && !(i_oe_n && i_cas_n);

    initial o_hold_n = 1'b1;

    // released lanes move every cycle, so stale data can never pass for a read
    always_comb begin
        for (int l = 0; l < 4; l++) begin
            o_data[8*l+:8] = pat ^ 8'(l);
            if (drive && l < (1 << i_wlg)) begin
                o_data[8*l+:8] = mem[12'((32'(i_addr) << i_wlg) | l)];
            end
        end
    end

    // stores follow enabled lanes; counters restart with each transfer
    always @(posedge i_clk) begin
        sel_q <= sel;
        pat <= pat + 8'h01;
        hcnt <= start ? 8'h00 : hcnt + 8'h01;
        // hcnt is still stale in the start cycle, so start itself must hold too
        o_hold_n <= !(i_slow && sel && (start || hcnt < 8'h0c));
        for (int l = 0; l < 4; l++) begin
            if (sel && i_doe && !i_lane_n[l] && l < (1 << i_wlg)) begin
                mem[12'((32'(i_addr) << i_wlg) | l)] <= i_data[8*l+:8];
            end
        end
        if (start) begin
            o_first <= i_addr;
            o_fsel <= i_sel_n;
        end
        o_oe_cnt <= (start ? 8'h00 : o_oe_cnt) + 8'(!i_oe_n);
        o_we_cnt <= (start ? 8'h00 : o_we_cnt) + 8'(!i_we_n);
        o_cas_cnt <= (start ? 8'h00 : o_cas_cnt) + 8'(!i_cas_n);
    end
endmodule // ebw_mem_model
